// File: hw/cnt_irq_pkg.sv
// Contract
// RULE1: Raise event when count reaches compare value
// RULE2: Only counters 0 and 1 interrupt
// RULE3: Event number 0-5 selects raised line
// RULE4: Rising enable arms; no event before
// RULE5: Caller matches select to counter axis
// RULE6: Busy true while function executes
// RULE7: Active true while controlling the channel
// RULE8: One event per match, again later
// RULE9: Compare value signed, sampled at arming
package cnt_irq_pkg;
    localparam int NUM_COUNTERS = 7;
    localparam int NUM_EVENTS = 6;
    localparam logic [15:0] MAX_IRQ_COUNTER = 16'h0001;
    localparam logic [15:0] MAX_EVENT = 16'h0005;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic [31:0] CMP_RESET = 32'h00000000;

    typedef struct packed {
        logic [15:0] counter_select;
        logic [15:0] event_number;
        logic signed [31:0] compare_value;
    } arm_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ARMED = 2'b10
    } irq_state_e;
endpackage

// File: hw/count_interrupt_block.sv
`timescale 1ns/10ps
module count_interrupt_block
    import cnt_irq_pkg::*;
(
    input wire logic sys_clk, // Clock 125 MHz
    input wire logic resetn, // Async reset, low
    input wire logic clk_en, // Clock enable
    input wire logic enable, // Execute level
    input wire arm_cfg_s cfg, // Select, event, compare
    input wire logic signed [31:0] count0, // Counter 0 value
    input wire logic signed [31:0] count1, // Counter 1 value
    output logic [NUM_EVENTS-1:0] event_pulse, // Event lines
    output logic busy, // Executing
    output logic active, // Controlling channel
    output logic error, // Reserved, low
    output logic [15:0] error_code // Reserved, zero
);
    ////////////////////////////////////////////////////////////
    irq_state_e state_q, state_d;
    arm_cfg_s cfg_q, cfg_d;
    logic enable_q, enable_d;
    logic busy_q, busy_d;
    logic active_q, active_d;
    logic [NUM_EVENTS-1:0] ev_q, ev_d;
    logic signed [31:0] sel_count;
    logic watch;
    logic hit;
    logic cfg_ok;

    // Settings take effect only at the enable edge
    assign cfg_ok = (cfg.counter_select <= MAX_IRQ_COUNTER) // RULE2
                    && (cfg.event_number <= MAX_EVENT); // RULE3
    assign sel_count = (cfg_q.counter_select == SEL_RESET) ? count0 : count1;
    assign watch = (state_q == ST_ARMED);

    match_detect u_match (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .watch(watch),
        .count_value(sel_count),
        .compare_value(cfg_q.compare_value),
        .hit(hit)
    );

    ////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        enable_d = enable;
        ev_d = '0;
        unique case (state_q)
            ST_IDLE: begin
                if (enable && !enable_q && cfg_ok) begin // RULE4
                    cfg_d = cfg; // RULE9
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (hit) begin
                    ev_d[cfg_q.event_number[2:0]] = 1'b1; // RULE1
                end
            end
            default: state_d = ST_IDLE;
        endcase
        busy_d = (state_d == ST_ARMED); // RULE6
        active_d = (state_d == ST_ARMED); // RULE7
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cfg_q <= '{SEL_RESET, SEL_RESET, CMP_RESET};
            enable_q <= 1'b0;
            ev_q <= '0;
            busy_q <= 1'b0;
            active_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            enable_q <= enable_d;
            ev_q <= ev_d;
            busy_q <= busy_d;
            active_q <= active_d;
        end
    end

    assign event_pulse = ev_q;
    assign busy = busy_q;
    assign active = active_q;
    assign error = 1'b0;
    assign error_code = ERR_NONE;
endmodule // count_interrupt_block

// File: hw/match_detect.sv
`timescale 1ns/10ps
module match_detect
    import cnt_irq_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Async reset, low
    input wire logic clk_en, // Clock enable
    input wire logic watch, // Comparison enabled
    input wire logic signed [31:0] count_value, // Selected count
    input wire logic signed [31:0] compare_value, // Target
    output logic hit // One-cycle on reaching target
);
    logic eq_q;
    logic eq_d;
    logic hit_q;
    logic hit_d;

    always_comb begin
        eq_d = watch && (count_value == compare_value);
        // First cycle of equality only; sitting on target gives one event
        hit_d = eq_d && !eq_q; // RULE8
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            eq_q <= 1'b0;
            hit_q <= 1'b0;
        end else if (clk_en) begin
            eq_q <= eq_d;
            hit_q <= hit_d;
        end
    end

    assign hit = hit_q;
endmodule // match_detect

// File: test/cnt_model.sv
`timescale 1ns/10ps
module cnt_model (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    output logic signed [31:0] count0, // Up
    output logic signed [31:0] count1 // Down
);
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn) {count0, count1} <= '0;
        else {count0, count1} <= {(count0 + 1) % 40, (count1 + 39) % 40};
endmodule // cnt_model

// File: test/count_interrupt_block_tb.sv
`timescale 1ns/10ps
module count_interrupt_block_tb;
    import cnt_irq_pkg::*;
    logic sys_clk = 0, resetn = 0, enable = 0, busy, active, error;
    logic signed [31:0] count0, count1;
    logic [5:0] event_pulse;
    logic [15:0] error_code;
    arm_cfg_s cfg = '0;
    int seed = 82, fail_count = 0, check_count = 0, cyc = 0, n, k, e;
    cnt_model cnt_model_inst (.*);
    count_interrupt_block count_interrupt_block_inst (.clk_en(1'b1), .*);
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cyc > 2000) results(1);
    function automatic int hits(arm_cfg_s c);
        return (c.counter_select < 2 && c.event_number < 6) ? 2 : 0;
    endfunction
    task check(logic [31:0] s, x);
        check_count++;
        if (s !== x) fail_count++;
        if (s !== x) $display("CHECK FAILED %0t %h %h", $time, s, x);
    endtask
    task results(int t);
        fail_count += t;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        resetn = 1;
        for (int i = 0; i < 16; i++) begin
            // Selects 2 and 3 must be refused
            cfg = {16'(i % 4), 16'($random(seed) & 7), 32'(1 + $unsigned($random(seed)) % 39)};
            e = hits(cfg);
            enable = 1;
            repeat (2) @(negedge sys_clk);
            check(busy, e > 0);
            check(active, e > 0);
            check({error, error_code}, 32'h00000000);
            {n, k} = 0;
            repeat (80) @(negedge sys_clk) begin
                n += (event_pulse >> cfg.event_number) == 1;
                k += event_pulse != 0;
            end
            check(n, e);
            check(k, e);
            enable = 0;
            repeat (3) @(negedge sys_clk);
            check(busy, 0);
            check(active, 0);
        end
        results(0);
    end
endmodule // count_interrupt_block_tb
bind count_interrupt_block irq_properties irq_properties_inst (.*);

// File: test/irq_properties.sv
`timescale 1ns/10ps
module irq_properties
    import cnt_irq_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic enable, // Run
    input wire arm_cfg_s cfg, // Setup
    input wire logic signed [31:0] count0, // Up
    input wire logic signed [31:0] count1, // Down
    input wire logic [5:0] event_pulse, // Events
    input wire logic busy, // Busy
    input wire logic active // Active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic eq = cfg.compare_value == (cfg.counter_select[0] ? count1 : count0);
    sequence s_gap; ##1 event_pulse == 0; endsequence
    a_flags_same: assert property (active == busy) else $error("flags");
    a_arm_now: assert property ($rose(enable) && !busy && cfg.counter_select < 2 &&
        cfg.event_number < 6 |=> busy) else $error("arm");
    a_arm_cause: assert property ($rose(busy) |-> $past(cfg.counter_select) < 2)
        else $error("select");
    a_busy_drop: assert property (busy && !enable |=> !busy) else $error("drop");
    a_one_pulse: assert property (event_pulse != 0 |-> s_gap) else $error("long");
    a_one_line: assert property ($onehot0(event_pulse)) else $error("lines");
    // Enable must still stand on the hit cycle, or the disarm wins over the event
    a_match_fire: assert property (busy && enable && $rose(eq) ##1 enable |->
        ##1 event_pulse == 6'h01 << cfg.event_number) else $error("miss");
    a_no_stray: assert property (event_pulse != 0 |-> $past(enable, 2) && $past(eq, 2))
        else $error("stray");
endmodule // irq_properties
